// >>> hdl/gpm_pkg.sv
// Functional notes
// R1 - path held off after insertion until OPEN_CIRCUIT_VOLTAGE done
// R2 - config bit inverts path output sense
// R3 - code 1: path off outside inhibit limits
// R4 - path back on inside limits narrowed by hysteresis
// R5 - presence pin tristated; high absent, low present
// R6 - presence pin polled once a second
// R7 - thermistor near 2.5 V means battery absent
// R8 - select bit picks thermistor, else on-chip sensor
// R9 - charge overtemp: limit held for duration, current above threshold
// R10 - charge duration 0 disables; clears at release level
// R11 - discharge overtemp: limit held, current at or below minus threshold
// R12 - discharge duration 0 disables; clears at release level
// R13 - charging ends: 2 taper windows, capacity over 0.25 mAh, voltage high
// R14 - termination with fill bit loads remaining with full capacity
// R15 - charging voltage 4200 mV by default, writable
// R16 - codes 0 and 2: charging temperature only on host request
// R17 - four power modes; normal when no other active
// R18 - sleep when enabled and current below sleep level, after calibration
// R19 - sleep ends on current above level or wake trip
// R20 - sleep may hold data line low up to 4 ms
// R21 - adapter, no battery: await; then OPEN_CIRCUIT_VOLTAGE, path, profile
// R22 - await mode services host commands, then waits again
// R23 - pin function codes 0/0, 0/1, 1/0; default 1
// R24 - polarity bit 0 by default, active-low enable
// R25 - wake comparator off when both sense bits 0
// R26 - signed measurements, configurable limits, compared per update tick
package gpm_pkg;
   // clock and time figures
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned POLL_PERIOD_MS = 1000;
   localparam int unsigned STALL_MAX_MS = 4;
   localparam int unsigned POLL_CYC = CLK_KHZ * POLL_PERIOD_MS;
   localparam int unsigned STALL_CYC = CLK_KHZ * STALL_MAX_MS;
   // register indices, byte address is four times the index
   localparam logic [3:0] IDX_CFG = 4'h0;
   localparam logic [3:0] IDX_INHIBIT = 4'h1;
   localparam logic [3:0] IDX_HYS_SLEEP = 4'h2;
   localparam logic [3:0] IDX_OTC_LIM = 4'h3;
   localparam logic [3:0] IDX_OTC_TIME = 4'h4;
   localparam logic [3:0] IDX_OTD_LIM = 4'h5;
   localparam logic [3:0] IDX_OTD_TIME = 4'h6;
   localparam logic [3:0] IDX_TAPER = 4'h7;
   localparam logic [3:0] IDX_CHG_VOLT = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   localparam logic [3:0] IDX_LAST_RW = 4'h8;
   // configuration bit positions
   localparam int CFG_EXT_THERMISTOR_SEL = 0;
   localparam int CFG_POL = 2;
   localparam int CFG_CAPACITY_FILL_ON_TERM = 4;
   localparam int CFG_SLEEP = 5;
   localparam int CFG_RSNS_LO = 8;
   localparam int CFG_RSNS_HI = 9;
   localparam int CFG_WAKE_LEVEL_SEL = 10;
   localparam int CFG_PFC_LO = 11;
   localparam int CFG_PFC_HI = 12;
   localparam logic [31:0] CFG_MASK = 32'h00001f35;
   localparam logic [31:0] CFG_RST = 32'h00000931;
   localparam logic [31:0] CHG_VOLT_RST = 32'h00001068;
   // pin function codes
   localparam logic [1:0] PFC0 = 2'h0;
   localparam logic [1:0] PFC1 = 2'h1;
   localparam logic [1:0] PFC2 = 2'h2;
   // capacity change per window, 0.01 mAh units
   localparam logic signed [15:0] CAP_MIN = 16'sh0019;
   localparam logic [1:0] TAPER_WINDOWS = 2'h2;
   // status bit positions
   localparam int ST_MODE = 0;
   localparam int ST_CHG = 3;
   localparam int ST_OTC = 4;
   localparam int ST_OTD = 5;
   localparam int ST_INHIBIT = 6;
   localparam int ST_PRESENT = 7;
   localparam int ST_PATH = 8;
   localparam int ST_STALL = 9;
   localparam int ST_ADAPTER = 10;
   localparam int ST_INIT = 11;

   typedef enum logic [2:0] {
      M_NORMAL, M_CALIB, M_SLEEP, M_HIBER, M_AWAIT, M_SERVICE, M_OCV
   } gpm_mode_t;

   // picks the low or high signed half of a register word
   function automatic logic signed [15:0] half(input logic [31:0] w, input logic hi);
      return hi ? w[31:16] : w[15:0];
   endfunction
endpackage

// >>> hdl/gpm_tick_div.sv
`timescale 1ns/10ps
module gpm_tick_div #(
   parameter int unsigned DIV = gpm_pkg::POLL_CYC
) (
   input wire logic ref_clk, // device clock
   input wire logic rst, // synchronous reset, high
   output logic tick // one-cycle enable every DIV cycles
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } gpm_div_state_t;

   gpm_div_state_t s;
   gpm_div_state_t next_s;

   ////////////////////////////////////////////////////////////
   // free-running divider, tick on wrap
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt == 32'(DIV - 1)) begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.cnt = s.cnt + 32'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule

// >>> hdl/gpm_ot_flag.sv
`timescale 1ns/10ps
module gpm_ot_flag (
   input wire logic ref_clk, // device clock
   input wire logic rst, // synchronous reset, high
   input wire logic tick, // measurement update
   input wire logic active, // charging or discharging phase
   input wire logic cur_ok, // current condition met
   input wire logic signed [15:0] temp, // current temperature
   input wire logic signed [15:0] limit, // set threshold
   input wire logic signed [15:0] release_lvl, // clear threshold
   input wire logic [15:0] duration, // ticks to persist, 0 disables
   output logic flag // overtemperature flag
);
   typedef struct packed {
      logic [15:0] cnt;
      logic flag;
   } gpm_ot_state_t;

   gpm_ot_state_t s;
   gpm_ot_state_t next_s;

   ////////////////////////////////////////////////////////////
   // persistence count; zero duration forces the flag off at once
   always_comb begin
      next_s = s;
      if (duration == 16'h0) begin
         next_s = '0; // see R10 see R12
      end else if (tick) begin
         if (s.flag) begin
            if (temp <= release_lvl) begin
               next_s.flag = 1'b0; // see R10 see R12
            end
         end else if (active && cur_ok && temp >= limit) begin
            next_s.cnt = s.cnt + 16'h1;
            if (s.cnt + 16'h1 >= duration) begin
               next_s.flag = 1'b1; // see R9 see R11
               next_s.cnt = '0;
            end
         end else begin
            next_s.cnt = '0; // a break restarts the period
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign flag = s.flag;
endmodule

// >>> hdl/gpm_ctrl.sv
`timescale 1ns/10ps
module gpm_ctrl #(
   parameter int unsigned POLL_CYC = gpm_pkg::POLL_CYC,
   parameter int unsigned STALL_CYC = gpm_pkg::STALL_CYC
) (
   input wire logic ref_clk, // device clock
   input wire logic rst, // synchronous reset, high
   input wire logic hsel, // bus select
   input wire logic [31:0] haddr, // bus address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready in
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   input wire logic meas_tick, // measurement update pulse
   input wire logic signed [15:0] temp_ext, // thermistor temperature
   input wire logic signed [15:0] temp_int, // on-chip temperature
   input wire logic signed [15:0] avg_current, // average current
   input wire logic signed [15:0] voltage, // cell voltage, mV
   input wire logic therm_open, // thermistor near 2.5 V
   input wire logic ocv_done, // OPEN_CIRCUIT_VOLTAGE reading complete pulse
   input wire logic calib_done, // offset calibration done pulse
   input wire logic window_tick, // end of taper window pulse
   input wire logic signed [15:0] cap_change, // capacity change in window
   input wire logic [15:0] full_capacity, // full charge capacity
   input wire logic wake_cmp, // wake comparator trip
   input wire logic host_cmd, // host command pending
   input wire logic cmd_done, // host command serviced pulse
   input wire logic host_temp_req, // host asks for temperature
   input wire logic hibernate_req, // hibernate entry qualified
   input wire logic sda_start, // host transaction start seen
   input wire logic adapter_in, // adapter present pin
   input wire logic presence_detect_pin_in, // presence pin level
   output logic presence_detect_pin_out, // presence pin drive value
   output logic presence_detect_pin_oe_n, // presence pin enable, low drives
   output logic sda_out, // data line drive value
   output logic sda_oe_n, // data line enable, low drives
   output logic power_path_enable_out, // power-path pin level
   output logic [2:0] wake_level_sel, // wake threshold select
   output logic ocv_start, // start OPEN_CIRCUIT_VOLTAGE reading pulse
   output logic calib_start, // start offset calibration pulse
   output logic profile_start, // start profile selection pulse
   output logic temp_sample, // temperature sampled pulse
   output logic rm_load, // remaining capacity load pulse
   output logic [15:0] rm_value // remaining capacity value
);
   typedef struct packed {
      logic [8:0][31:0] regs;
      logic [31:0] rdata;
      logic wr_pend;
      logic [3:0] wr_idx;
      gpm_pkg::gpm_mode_t mode;
      logic pres_s1;
      logic pres_s2;
      logic adp_s1;
      logic adp_s2;
      logic present;
      logic init_done;
      logic inhibit;
      logic chg;
      logic term_hold;
      logic [1:0] taper_cnt;
      logic signed [15:0] temp;
      logic stall;
      logic [18:0] stall_cnt;
      logic ocv_start;
      logic calib_start;
      logic profile_start;
      logic temp_sample;
      logic rm_load;
      logic [15:0] rm_value;
      logic path_out;
   } gpm_ctrl_state_t;

   gpm_ctrl_state_t s;
   gpm_ctrl_state_t next_s;
   logic poll_tick;
   logic charge_overtemp_flag;
   logic discharge_overtemp_flag;
   logic [31:0] cfg;
   logic [1:0] pin_function_code;
   logic signed [15:0] inh_lo;
   logic signed [15:0] inh_hi;
   logic signed [15:0] hys;
   logic signed [15:0] sleep_cur;
   logic signed [15:0] chg_thr;
   logic signed [15:0] dsg_thr;
   logic signed [15:0] taper_cur;
   logic signed [15:0] taper_volt;
   logic signed [15:0] chg_volt;
   logic wake_en;
   logic bus_take;
   logic [31:0] status;

   ////////////////////////////////////////////////////////////
   // config fields from register words
   assign cfg = s.regs[gpm_pkg::IDX_CFG];
   assign pin_function_code = {cfg[gpm_pkg::CFG_PFC_HI], cfg[gpm_pkg::CFG_PFC_LO]}; // see R23
   assign inh_lo = gpm_pkg::half(s.regs[gpm_pkg::IDX_INHIBIT], 1'b0);
   assign inh_hi = gpm_pkg::half(s.regs[gpm_pkg::IDX_INHIBIT], 1'b1);
   assign hys = gpm_pkg::half(s.regs[gpm_pkg::IDX_HYS_SLEEP], 1'b0);
   assign sleep_cur = gpm_pkg::half(s.regs[gpm_pkg::IDX_HYS_SLEEP], 1'b1);
   assign chg_thr = gpm_pkg::half(s.regs[gpm_pkg::IDX_OTC_TIME], 1'b1);
   assign dsg_thr = gpm_pkg::half(s.regs[gpm_pkg::IDX_OTD_TIME], 1'b1);
   assign taper_cur = gpm_pkg::half(s.regs[gpm_pkg::IDX_TAPER], 1'b0);
   assign taper_volt = gpm_pkg::half(s.regs[gpm_pkg::IDX_TAPER], 1'b1);
   assign chg_volt = gpm_pkg::half(s.regs[gpm_pkg::IDX_CHG_VOLT], 1'b0); // see R15
   // no sense resistor selected means no wake comparator trip; current above the sleep level still wakes
   assign wake_en = cfg[gpm_pkg::CFG_RSNS_HI] | cfg[gpm_pkg::CFG_RSNS_LO]; // see R25
   assign wake_level_sel = {cfg[gpm_pkg::CFG_RSNS_HI], cfg[gpm_pkg::CFG_RSNS_LO], cfg[gpm_pkg::CFG_WAKE_LEVEL_SEL]};

   // address phase accepted only for word transfers
   assign bus_take = hsel && htrans[1] && hready && (hsize == 3'h2);

   ////////////////////////////////////////////////////////////
   // presence poll and overtemperature flags
   gpm_tick_div #(
      .DIV(POLL_CYC)
   ) u_poll (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(poll_tick)
   );

   gpm_ot_flag u_otc (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(meas_tick),
      .active(s.chg),
      .cur_ok(avg_current > chg_thr), // see R9
      .temp(s.temp),
      .limit(gpm_pkg::half(s.regs[gpm_pkg::IDX_OTC_LIM], 1'b0)),
      .release_lvl(gpm_pkg::half(s.regs[gpm_pkg::IDX_OTC_LIM], 1'b1)),
      .duration(s.regs[gpm_pkg::IDX_OTC_TIME][15:0]),
      .flag(charge_overtemp_flag)
   );

   gpm_ot_flag u_otd (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(meas_tick),
      .active(!s.chg),
      .cur_ok(avg_current <= 16'(-dsg_thr)), // see R11
      .temp(s.temp),
      .limit(gpm_pkg::half(s.regs[gpm_pkg::IDX_OTD_LIM], 1'b0)),
      .release_lvl(gpm_pkg::half(s.regs[gpm_pkg::IDX_OTD_LIM], 1'b1)),
      .duration(s.regs[gpm_pkg::IDX_OTD_TIME][15:0]),
      .flag(discharge_overtemp_flag)
   );

   ////////////////////////////////////////////////////////////
   // read-only status word
   always_comb begin
      status = '0;
      status[gpm_pkg::ST_MODE +: 3] = s.mode;
      status[gpm_pkg::ST_CHG] = s.chg;
      status[gpm_pkg::ST_OTC] = charge_overtemp_flag;
      status[gpm_pkg::ST_OTD] = discharge_overtemp_flag;
      status[gpm_pkg::ST_INHIBIT] = s.inhibit;
      status[gpm_pkg::ST_PRESENT] = s.present;
      status[gpm_pkg::ST_PATH] = s.path_out;
      status[gpm_pkg::ST_STALL] = s.stall;
      status[gpm_pkg::ST_ADAPTER] = s.adp_s2;
      status[gpm_pkg::ST_INIT] = s.init_done;
   end

   ////////////////////////////////////////////////////////////
   // next-state logic for the whole block
   always_comb begin
      next_s = s;
      next_s.ocv_start = 1'b0;
      next_s.calib_start = 1'b0;
      next_s.profile_start = 1'b0;
      next_s.temp_sample = 1'b0;
      next_s.rm_load = 1'b0;

      // pin synchronisers, first stage feeds only the second
      next_s.pres_s1 = presence_detect_pin_in;
      next_s.pres_s2 = s.pres_s1;
      next_s.adp_s1 = adapter_in;
      next_s.adp_s2 = s.adp_s1;

      // bus data phase: write lands first so a following read sees it
      next_s.wr_pend = 1'b0;
      if (s.wr_pend && s.wr_idx <= gpm_pkg::IDX_LAST_RW) begin
         if (s.wr_idx == gpm_pkg::IDX_CFG) begin
            next_s.regs[s.wr_idx] = hwdata & gpm_pkg::CFG_MASK;
         end else begin
            next_s.regs[s.wr_idx] = hwdata;
         end
      end
      if (bus_take) begin
         next_s.wr_pend = hwrite;
         next_s.wr_idx = haddr[5:2];
         next_s.rdata = '0; // unmapped reads return zero
         if (haddr[31:6] == 26'h0) begin
            if (haddr[5:2] <= gpm_pkg::IDX_LAST_RW) begin
               next_s.rdata = next_s.regs[haddr[5:2]];
            end else if (haddr[5:2] == gpm_pkg::IDX_STATUS) begin
               next_s.rdata = status;
            end
         end
         if (haddr[31:6] != 26'h0) begin
            next_s.wr_pend = 1'b0; // out-of-range writes dropped
         end
      end

      // presence poll: pin is only listened to, low means a battery
      if (poll_tick) begin
         next_s.present = !s.pres_s2 && !therm_open; // see R5 see R6 see R7
      end

      // temperature source and when sampling is allowed
      if (host_temp_req || (meas_tick && !(s.chg && pin_function_code != gpm_pkg::PFC1))) begin // see R16
         next_s.temp_sample = 1'b1;
         next_s.temp = cfg[gpm_pkg::CFG_EXT_THERMISTOR_SEL] ? temp_ext : temp_int; // see R8
      end

      // charge inhibit window with hysteresis, only in code 1
      if (pin_function_code != gpm_pkg::PFC1) begin
         next_s.inhibit = 1'b0;
      end else if (meas_tick) begin // see R26
         if (!s.inhibit && (s.temp < inh_lo || s.temp > inh_hi)) begin
            next_s.inhibit = 1'b1; // see R3
         end else if (s.inhibit && s.temp >= 16'(inh_lo + hys) && s.temp <= 16'(inh_hi - hys)) begin
            next_s.inhibit = 1'b0; // see R4
         end
      end

      // charging flag; termination holds it off until current falls
      if (meas_tick) begin
         if (!s.chg && !s.term_hold && avg_current > chg_thr) begin
            next_s.chg = 1'b1;
            next_s.taper_cnt = '0;
         end
         if (s.term_hold && avg_current <= chg_thr) begin
            next_s.term_hold = 1'b0;
         end
      end
      if (window_tick && s.chg) begin
         if (avg_current < taper_cur && cap_change > gpm_pkg::CAP_MIN) begin
            if (s.taper_cnt != gpm_pkg::TAPER_WINDOWS) begin
               next_s.taper_cnt = s.taper_cnt + 2'h1;
            end
         end else begin
            next_s.taper_cnt = '0; // windows must be consecutive
         end
         if (next_s.taper_cnt == gpm_pkg::TAPER_WINDOWS && voltage > 16'(chg_volt - taper_volt)) begin
            next_s.chg = 1'b0; // see R13
            next_s.term_hold = 1'b1;
            next_s.taper_cnt = '0;
            if (cfg[gpm_pkg::CFG_CAPACITY_FILL_ON_TERM]) begin
               next_s.rm_load = 1'b1; // see R14
               next_s.rm_value = full_capacity;
            end
         end
      end

      // power mode machine
      case (s.mode)
         gpm_pkg::M_AWAIT: begin
            if (host_cmd) begin
               next_s.mode = gpm_pkg::M_SERVICE; // see R22
            end else if (s.present) begin
               next_s.mode = gpm_pkg::M_OCV; // see R21
               next_s.ocv_start = 1'b1;
            end
         end
         gpm_pkg::M_SERVICE: begin
            if (cmd_done) begin
               next_s.mode = gpm_pkg::M_AWAIT; // see R22
            end
         end
         gpm_pkg::M_OCV: begin
            if (ocv_done) begin
               next_s.init_done = 1'b1; // see R1
               next_s.profile_start = 1'b1; // see R21
               next_s.mode = gpm_pkg::M_NORMAL;
            end
         end
         gpm_pkg::M_NORMAL: begin
            if (hibernate_req) begin
               next_s.mode = gpm_pkg::M_HIBER;
            end else if (meas_tick && cfg[gpm_pkg::CFG_SLEEP] && avg_current < sleep_cur) begin
               next_s.mode = gpm_pkg::M_CALIB; // see R18
               next_s.calib_start = 1'b1;
            end
         end
         gpm_pkg::M_CALIB: begin
            if (calib_done) begin
               next_s.mode = gpm_pkg::M_SLEEP; // see R18
            end
         end
         gpm_pkg::M_SLEEP: begin
            if ((meas_tick && avg_current > sleep_cur) || (wake_cmp && wake_en)) begin
               next_s.mode = gpm_pkg::M_NORMAL; // see R19
            end
         end
         gpm_pkg::M_HIBER: begin
            if (host_cmd) begin
               next_s.mode = gpm_pkg::M_NORMAL;
            end
         end
         default: begin
            next_s.mode = gpm_pkg::M_NORMAL; // see R17
         end
      endcase

      // battery loss drops initialisation; with an adapter, wait
      if (!s.present) begin
         next_s.init_done = 1'b0;
         if (s.adp_s2 && s.mode != gpm_pkg::M_AWAIT && s.mode != gpm_pkg::M_SERVICE) begin
            next_s.mode = gpm_pkg::M_AWAIT; // see R21
         end
      end else if (!s.init_done && s.mode != gpm_pkg::M_OCV && s.mode != gpm_pkg::M_AWAIT
                   && s.mode != gpm_pkg::M_SERVICE) begin
         next_s.mode = gpm_pkg::M_OCV; // see R1
         next_s.ocv_start = 1'b1;
      end

      // data-line stall in sleep; bounded so the host never waits long
      if (s.stall) begin
         next_s.stall_cnt = s.stall_cnt + 19'h1;
         if (s.stall_cnt == 19'(STALL_CYC - 1) || s.mode != gpm_pkg::M_SLEEP) begin
            next_s.stall = 1'b0; // see R20
         end
      end else if (s.mode == gpm_pkg::M_SLEEP && sda_start) begin
         next_s.stall = 1'b1; // see R20
         next_s.stall_cnt = '0;
      end

      // enable needs a finished OPEN_CIRCUIT_VOLTAGE, a battery and no inhibit
      next_s.path_out = (next_s.init_done && next_s.present && !next_s.inhibit)
                        ^ !cfg[gpm_pkg::CFG_POL]; // see R1 see R2 see R24 see R3
   end

   ////////////////////////////////////////////////////////////
   // state register with constant reset values
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s <= '0;
         s.regs[gpm_pkg::IDX_CFG] <= gpm_pkg::CFG_RST;
         s.regs[gpm_pkg::IDX_CHG_VOLT] <= gpm_pkg::CHG_VOLT_RST;
         s.mode <= gpm_pkg::M_AWAIT;
         s.path_out <= 1'b1; // disabled at default polarity
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs
   assign hrdata = s.rdata;
   assign hreadyout = 1'b1; // zero wait states
   assign hresp = 1'b0;
   assign presence_detect_pin_out = 1'b0;
   assign presence_detect_pin_oe_n = 1'b1; // never driven, see R5
   assign sda_out = 1'b0;
   assign sda_oe_n = !s.stall;
   assign power_path_enable_out = s.path_out;
   assign ocv_start = s.ocv_start;
   assign calib_start = s.calib_start;
   assign profile_start = s.profile_start;
   assign temp_sample = s.temp_sample;
   assign rm_load = s.rm_load;
   assign rm_value = s.rm_value;
endmodule

// >>> bench/gpm_host_model.sv
`timescale 1ns/10ps
module gpm_batt_host (
   input wire logic bat_in, // battery fitted
   input wire logic pin_out, // device pin value
   input wire logic pin_oe_n, // device pin enable
   input wire logic sda_out, // device data value
   input wire logic sda_oe_n, // device data enable
   output logic pin_level, // resolved presence pin
   output logic sda_level // resolved data line
);
   // weak pull-up holds the pin high unless a cell pulls it low
   assign pin_level = !pin_oe_n ? pin_out : !bat_in;
   // host simply waits out a held-low data line
   assign sda_level = !sda_oe_n ? sda_out : 1'b1;
endmodule

// >>> bench/gpm_ctrl_monitor.sv
`timescale 1ns/10ps
module gpm_chk #(
   parameter int unsigned STALL_CYC = 20
) (
   input wire logic ref_clk, // clock
   input wire logic rst, // reset
   input wire logic meas_tick, // update
   input wire logic ocv_done, // ocv end
   input wire logic window_tick, // taper window
   input wire logic host_temp_req, // host asks
   input wire logic sda_start, // host start
   input wire logic [15:0] full_capacity, // full value
   input wire logic presence_detect_pin_oe_n, // pin enable
   input wire logic sda_oe_n, // stall drive
   input wire logic ocv_start, // ocv begin
   input wire logic calib_start, // calib begin
   input wire logic profile_start, // profile begin
   input wire logic temp_sample, // temp taken
   input wire logic rm_load, // load pulse
   input wire logic [15:0] rm_value // load data
);
   int unsigned low_cnt;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // length of a stall; one spare cycle for the release edge
   always_ff @(posedge ref_clk) begin
      low_cnt <= (rst || sda_oe_n) ? 0 : low_cnt + 1;
   end
   property p_tri; presence_detect_pin_oe_n; endproperty
   a_tri: assert property (p_tri) else $error("presence pin driven");
   property p_prof; profile_start |-> $past(ocv_done); endproperty
   a_prof: assert property (p_prof) else $error("profile before ocv end");
   property p_ocv; ocv_start |=> !ocv_start; endproperty
   a_ocv: assert property (p_ocv) else $error("ocv start too long");
   property p_stl; $fell(sda_oe_n) |-> $past(sda_start); endproperty
   a_stl: assert property (p_stl) else $error("stall without start");
   property p_len; low_cnt <= STALL_CYC + 1; endproperty
   a_len: assert property (p_len) else $error("stall too long");
   property p_cal; calib_start |-> $past(meas_tick); endproperty
   a_cal: assert property (p_cal) else $error("calib without update");
   property p_rm; rm_load |-> rm_value == $past(full_capacity) && $past(window_tick); endproperty
   a_rm: assert property (p_rm) else $error("bad capacity load");
   property p_tmp; temp_sample |-> $past(meas_tick || host_temp_req); endproperty
   a_tmp: assert property (p_tmp) else $error("temp sample without cause");
endmodule
bind gpm_ctrl gpm_chk #(.STALL_CYC(STALL_CYC)) chk_u (.*);

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0, bat = 0, wake = 0, pw, pin_in, pin_o, pin_oe, sda_o, sda_oe;
   logic hrdy, ocv_go;
   logic [5:0] pul = 6'h0;
   logic [4:0] aux = 5'h01;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
   logic signed [15:0] temp = 16'sh0, avg = 16'sh0, cap = 16'sh0;
   logic [15:0] rmv;
   int n, bad_count = 0, checked = 0;
   always #4 ref_clk = !ref_clk;
   gpm_ctrl #(.POLL_CYC(64), .STALL_CYC(20)) dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata),
      .hreadyout(hrdy), .hresp(), .meas_tick(pul[5]), .temp_ext(temp), .temp_int(16'sh0), .avg_current(avg),
      .voltage(16'sh1036), .therm_open(aux[4]), .ocv_done(pul[4]), .calib_done(pul[3]), .window_tick(pul[2]),
      .cap_change(cap), .full_capacity(16'h1234), .wake_cmp(wake), .host_cmd(aux[3]), .cmd_done(aux[2]),
      .host_temp_req(pul[0]), .hibernate_req(aux[1]), .sda_start(pul[1]), .adapter_in(aux[0]),
      .presence_detect_pin_in(pin_in), .presence_detect_pin_out(pin_o), .presence_detect_pin_oe_n(pin_oe),
      .sda_out(sda_o), .sda_oe_n(sda_oe), .power_path_enable_out(pw), .wake_level_sel(), .ocv_start(ocv_go),
      .calib_start(), .profile_start(), .temp_sample(), .rm_load(), .rm_value(rmv));
   gpm_batt_host host_u (.bat_in(bat), .pin_out(pin_o), .pin_oe_n(pin_oe), .sda_out(sda_o), .sda_oe_n(sda_oe),
      .pin_level(pin_in), .sda_level());
   task test_done;
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
         bad_count++;
      end
   endtask
   // bounded wait for hready at a rising edge
   task rdy;
      for (int k = 0; k < 20; k++) begin
         @(posedge ref_clk);
         if (hrdy === 1'b1) return;
      end
      bad_count++;
      test_done;
   endtask
   // one single word transfer; read data lands in v
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
      rdy();
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      rdy();
      v = hrdata;
   endtask
   task st(input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, 32'h24, 32'h0);
      chk(v & m, e);
   endtask
   // strobe set {tick, ocv, calib, window, start, temp}, then let it settle
   task pl(input logic [5:0] m);
      @(posedge ref_clk) pul <= m;
      @(posedge ref_clk) pul <= 6'h0;
      repeat (2) @(negedge ref_clk);
   endtask
   task tk(input int c);
      repeat (c) pl(6'h20);
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      bus(1'b0, 32'h0, 32'h0);
      chk(v, 32'h931);
      bus(1'b0, 32'h20, 32'h0);
      chk(v, 32'h1068);
      bus(1'b0, 32'h40, 32'h0);
      chk(v, 32'h0);
      bat <= 1'b1;
      for (n = 0; n < 300 && ocv_go !== 1'b1; n++) @(negedge ref_clk);
      chk(n < 300, 32'h1);
      chk(pw, 32'h1);
      pl(6'h10);
      chk(pw, 32'h0);
      bus(1'b1, 32'h0, 32'h935);
      repeat (3) @(negedge ref_clk);
      chk(pw, 32'h1);
      bus(1'b1, 32'h0, 32'h931);
      bus(1'b1, 32'h4, 32'h00640000);
      bus(1'b1, 32'h8, 32'h5);
      // inhibit above the high limit, then the hysteresis band
      temp <= 16'sd110;
      tk(2);
      chk(pw, 32'h1);
      temp <= 16'sd98;
      tk(2);
      chk(pw, 32'h1);
      temp <= 16'sd94;
      tk(2);
      chk(pw, 32'h0);
      bus(1'b1, 32'h0c, 32'h00280032);
      bus(1'b1, 32'h10, 32'h000a0002);
      {avg, temp} <= {16'sd20, 16'sd60};
      tk(1);
      st(32'h18, 32'h08);
      tk(3);
      st(32'h18, 32'h18);
      temp <= 16'sd40;
      tk(2);
      st(32'h18, 32'h08);
      temp <= 16'sd60;
      bus(1'b1, 32'h10, 32'h000a0000);
      tk(4);
      st(32'h18, 32'h08);
      // termination needs two back-to-back qualifying windows
      bus(1'b1, 32'h1c, 32'h0064001e);
      cap <= 16'sd26;
      pl(6'h04);
      st(32'h08, 32'h08);
      pl(6'h04);
      chk(rmv, 32'h1234);
      st(32'h08, 32'h0);
      avg <= 16'sd0;
      bus(1'b1, 32'h8, 32'h000a0005);
      tk(1);
      st(32'h7, 32'h1);
      pl(6'h08);
      st(32'h7, 32'h2);
      pl(6'h02);
      chk(sda_oe, 32'h0);
      repeat (30) @(negedge ref_clk);
      chk(sda_oe, 32'h1);
      pl(6'h01);
      wake <= 1'b1;
      repeat (3) @(negedge ref_clk);
      st(32'h7, 32'h0);
      bat <= 1'b0;
      repeat (80) @(negedge ref_clk);
      chk(pw, 32'h1);
      st(32'h7, 32'h4);
      aux <= 5'h09;
      repeat (3) @(negedge ref_clk);
      st(32'h7, 32'h5);
      test_done;
   end
endmodule
